/* File: cpucr_pkg.sv */
/*
  Constants and types shared by the core reset and opcode handling block.
  Assumes a single 50 MHz crystal clock feeding the block.
*/
package cpucr_pkg;

  // ***************************************************************
  // Clocking and reset values
  // ***************************************************************
  localparam int          XTAL_MHZ       = 50;
  localparam int          CORE_DIV       = 2;
  localparam int          NUM_SEGS       = 6;
  localparam logic [31:0] IP_RST         = 32'hFFFF_FFF0;
  localparam logic [31:0] SEG_BASE_RST   = 32'h0000_0000;
  localparam logic [31:0] SEG_LIMIT_RST  = 32'h0FFF_FFFF;
  localparam logic [31:0] CR0_RST        = 32'h0000_0001;
  localparam logic [31:0] CR0_WMASK      = 32'h0000_002E;
  localparam int          CR0_PE_BIT     = 0;
  localparam logic [31:0] FLAGS_RST      = 32'h0000_0002;
  localparam logic [31:0] FLAGS_WMASK    = 32'h0024_7FD5;
  localparam logic [31:0] FLAGS_SET      = 32'h0000_0002;
  localparam logic [31:0] CR_UNDEF_READ  = 32'h0000_0000;

  // ***************************************************************
  // Opcode encodings
  // ***************************************************************
  localparam logic [7:0] OP_ESC_LO      = 8'hD8;
  localparam logic [7:0] OP_ESC_HI      = 8'hDF;
  localparam logic [7:0] OP_WAIT        = 8'h9B;
  localparam logic [7:0] OP_TWO_BYTE    = 8'h0F;
  localparam logic [7:0] OP2_WB_INVAL   = 8'h09;
  localparam logic [7:0] OP2_GROUP7     = 8'h01;
  localparam logic [2:0] GRP7_TE_INVAL  = 3'h7;
  localparam logic [7:0] OP2_MOV_FR_CR  = 8'h20;
  localparam logic [7:0] OP2_MOV_TO_CR  = 8'h22;
  localparam logic [2:0] CR_NUM_0       = 3'h0;
  localparam logic [2:0] CR_NUM_2       = 3'h2;
  localparam logic [2:0] CR_NUM_3       = 3'h3;

  // ***************************************************************
  // Instruction cache geometry
  // ***************************************************************
  localparam int IC_BYTES = 1024;
  localparam int IC_WORDS = IC_BYTES / 4;
  localparam int IC_IDX_W = 8;
  localparam int IC_TAG_W = 32 - IC_IDX_W - 2;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0]
  {
    OPC_NORMAL    = 3'b000,
    OPC_ESC_TRAP  = 3'b001,
    OPC_WAIT_NOP  = 3'b010,
    OPC_INVALID   = 3'b011,
    OPC_CR_NOP    = 3'b100,
    OPC_CR_RD_NOP = 3'b101,
    OPC_CR0_WRITE = 3'b110,
    OPC_CR0_READ  = 3'b111
  } cpucr_op_type;

  typedef enum logic [1:0]
  {
    RS_HOLD = 2'b00,
    RS_LOAD = 2'b01,
    RS_RUN  = 2'b10
  } cpucr_rst_type;

endpackage

/* File: cpucr_op_decode.sv */
/*
  Opcode classifier for the core's non-standard instruction handling.
  Assumes the first opcode byte, the second byte and the modrm byte are
  presented together and are stable for the cycle they are sampled.
*/
`timescale 1ns/1ps
module cpucr_op_decode
  import cpucr_pkg::*;
(
  input  wire logic [7:0]   byte0,
  input  wire logic [7:0]   byte1,
  input  wire logic [7:0]   modrm,
  output cpucr_pkg::cpucr_op_type op_class
);

  logic [2:0] reg_field;

  assign reg_field = modrm[5:3];

  always_comb
  begin
    op_class = OPC_NORMAL;
    if (byte0 >= OP_ESC_LO && byte0 <= OP_ESC_HI)
    begin
      op_class = OPC_ESC_TRAP;
    end
    else if (byte0 == OP_WAIT)
    begin
      op_class = OPC_WAIT_NOP;
    end
    else if (byte0 == OP_TWO_BYTE)
    begin
      if (byte1 == OP2_WB_INVAL)
      begin
        op_class = OPC_INVALID;
      end
      else if (byte1 == OP2_GROUP7 && reg_field == GRP7_TE_INVAL)
      begin
        op_class = OPC_INVALID;
      end
      else if (byte1 == OP2_MOV_TO_CR)
      begin
        if (reg_field == CR_NUM_0)
          op_class = OPC_CR0_WRITE;
        else if (reg_field == CR_NUM_2 || reg_field == CR_NUM_3)
          op_class = OPC_CR_NOP;
        else
          op_class = OPC_INVALID;
      end
      else if (byte1 == OP2_MOV_FR_CR)
      begin
        if (reg_field == CR_NUM_0)
          op_class = OPC_CR0_READ;
        else if (reg_field == CR_NUM_2 || reg_field == CR_NUM_3)
          op_class = OPC_CR_RD_NOP;
        else
          op_class = OPC_INVALID;
      end
    end
  end

endmodule

/* File: cpucr_core_ctl.sv */
/*
  Core control: reset sequencing from power-good, boot width strap,
  architectural reset state, three-stage opcode pipeline, 1 KB
  instruction-only cache, address pass-through and data bus drive.
  Assumes mclk is the crystal clock and only power-good, the strap and the data bus input are asynchronous.
*/
`timescale 1ns/1ps
module cpucr_core_ctl
  import cpucr_pkg::*;
#(
  // Arbitrary neutral value
  parameter logic [31:0] REVISION_CODE = 32'h0000_0A5C
)
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        power_good_input,
  input  wire logic        byte_high_enable_strap,
  output logic             core_clk,
  output logic             core_reset,
  output logic             boot_16bit,
  input  wire logic        op_valid,
  input  wire logic [7:0]  op_byte0,
  input  wire logic [7:0]  op_byte1,
  input  wire logic [7:0]  op_modrm,
  input  wire logic [31:0] op_data,
  output logic             op_ready,
  output logic             escape_trap,
  output logic             invalid_opcode_trap,
  output logic             nop_done,
  output logic             exec_done,
  output logic [31:0]      result_data,
  input  wire logic        ip_load,
  input  wire logic [31:0] ip_in,
  input  wire logic        flags_wr,
  input  wire logic [31:0] flags_in,
  input  wire logic        seg_load,
  input  wire logic [2:0]  seg_sel,
  input  wire logic [31:0] seg_base_in,
  input  wire logic [31:0] seg_limit_in,
  output logic [NUM_SEGS*32-1:0] seg_base_all,
  output logic [NUM_SEGS*32-1:0] seg_limit_all,
  output logic [31:0]      instruction_pointer,
  output logic [31:0]      revision_report_register,
  output logic [31:0]      cr0_value,
  output logic [31:0]      flags_register,
  output logic             protected_mode,
  output logic             default_32bit_code_size,
  input  wire logic [31:0] linear_address,
  output logic [31:0]      physical_address,
  input  wire logic        fetch_req,
  input  wire logic [31:0] fetch_addr,
  output logic             fetch_hit,
  output logic [31:0]      fetch_data,
  input  wire logic        fill_valid,
  input  wire logic [31:0] fill_addr,
  input  wire logic [31:0] fill_data,
  input  wire logic        bus_wr_req,
  input  wire logic [15:0] bus_wr_data,
  output logic [15:0]      bus_rd_data,
  input  wire logic [15:0] system_data_bus_in,
  output logic [15:0]      system_data_bus_out,
  output logic             system_data_bus_oe_n
);

  // ***************************************************************
  // Clock divider
  // ***************************************************************
  logic next_core_clk;

  always_comb
  begin
    next_core_clk = ~core_clk;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      core_clk <= 1'b0;
    else
      core_clk <= next_core_clk;
  end

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic pg_s1;
  logic pg_s2;
  logic pg_d;
  logic strap_s1;
  logic strap_s2;
  logic pg_rise;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pg_s1    <= 1'b0;
      pg_s2    <= 1'b0;
      pg_d     <= 1'b0;
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
    end
    else
    begin
      pg_s1    <= power_good_input;
      pg_s2    <= pg_s1;
      pg_d     <= pg_s2;
      strap_s1 <= byte_high_enable_strap;
      strap_s2 <= strap_s1;
    end
  end

  assign pg_rise = pg_s2 & ~pg_d;

  // ***************************************************************
  // Reset sequencer and strap capture
  // ***************************************************************
  cpucr_rst_type rst_state;
  cpucr_rst_type next_rst_state;
  logic          next_boot_16bit;
  logic          running;
  logic          arch_load;

  always_comb
  begin
    next_rst_state  = rst_state;
    next_boot_16bit = boot_16bit;
    if (pg_rise)
      next_boot_16bit = strap_s2;
    case (rst_state)
      RS_HOLD:
        if (pg_rise)
          next_rst_state = RS_LOAD;
      RS_LOAD:
        next_rst_state = pg_s2 ? RS_RUN : RS_HOLD;
      RS_RUN:
        if (!pg_s2)
          next_rst_state = RS_HOLD;
      default:
        next_rst_state = RS_HOLD;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_state  <= RS_HOLD;
      boot_16bit <= 1'b0;
    end
    else
    begin
      rst_state  <= next_rst_state;
      boot_16bit <= next_boot_16bit;
    end
  end

  assign running    = (rst_state == RS_RUN);
  assign arch_load  = (rst_state == RS_LOAD);
  assign core_reset = ~running;
  assign op_ready   = running;

  // ***************************************************************
  // Three-stage pipeline: latch, classify, execute
  // ***************************************************************
  cpucr_op_type dec_class;
  logic         s1_valid;
  logic [7:0]   s1_b0;
  logic [7:0]   s1_b1;
  logic [7:0]   s1_modrm;
  logic [31:0]  s1_data;
  logic         s2_valid;
  cpucr_op_type s2_class;
  logic [31:0]  s2_data;
  logic         next_s1_valid;
  logic         next_s2_valid;

  cpucr_op_decode u_decode
  (
    .byte0    (s1_b0),
    .byte1    (s1_b1),
    .modrm    (s1_modrm),
    .op_class (dec_class)
  );

  always_comb
  begin
    next_s1_valid = running & op_valid;
    next_s2_valid = running & s1_valid;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_valid <= 1'b0;
      s1_b0    <= 8'h00;
      s1_b1    <= 8'h00;
      s1_modrm <= 8'h00;
      s1_data  <= 32'h0000_0000;
      s2_valid <= 1'b0;
      s2_class <= OPC_NORMAL;
      s2_data  <= 32'h0000_0000;
    end
    else
    begin
      s1_valid <= next_s1_valid;
      s1_b0    <= op_byte0;
      s1_b1    <= op_byte1;
      s1_modrm <= op_modrm;
      s1_data  <= op_data;
      s2_valid <= next_s2_valid;
      s2_class <= dec_class;
      s2_data  <= s1_data;
    end
  end

  // ***************************************************************
  // Execute stage results
  // ***************************************************************
  logic        next_escape_trap;
  logic        next_invalid;
  logic        next_nop_done;
  logic        next_exec_done;
  logic [31:0] next_result;
  logic        ex_go;

  assign ex_go = s2_valid & running;

  always_comb
  begin
    next_escape_trap = 1'b0;
    next_invalid     = 1'b0;
    next_nop_done    = 1'b0;
    next_exec_done   = 1'b0;
    next_result      = result_data;
    if (ex_go)
    begin
      case (s2_class)
        OPC_ESC_TRAP:
          next_escape_trap = 1'b1;
        OPC_INVALID:
          next_invalid = 1'b1;
        OPC_WAIT_NOP:
          next_nop_done = 1'b1;
        OPC_CR_NOP:
          next_nop_done = 1'b1;
        OPC_CR_RD_NOP:
        begin
          next_nop_done = 1'b1;
          next_result   = CR_UNDEF_READ;
        end
        OPC_CR0_READ:
        begin
          next_exec_done = 1'b1;
          next_result    = cr0_value;
        end
        default:
          next_exec_done = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      escape_trap         <= 1'b0;
      invalid_opcode_trap <= 1'b0;
      nop_done            <= 1'b0;
      exec_done           <= 1'b0;
      result_data         <= 32'h0000_0000;
    end
    else
    begin
      escape_trap         <= next_escape_trap;
      invalid_opcode_trap <= next_invalid;
      nop_done            <= next_nop_done;
      exec_done           <= next_exec_done;
      result_data         <= next_result;
    end
  end

  // ***************************************************************
  // Architectural registers
  // ***************************************************************
  logic [31:0] next_ip;
  logic [31:0] next_rev;
  logic [31:0] next_cr0;
  logic [31:0] next_flags;
  logic        next_code32;

  always_comb
  begin
    next_ip     = instruction_pointer;
    next_rev    = revision_report_register;
    next_cr0    = cr0_value;
    next_flags  = flags_register;
    next_code32 = default_32bit_code_size;
    if (arch_load)
    begin
      next_ip     = IP_RST;
      next_rev    = REVISION_CODE;
      next_cr0    = CR0_RST;
      next_flags  = FLAGS_RST;
      next_code32 = 1'b1;
    end
    else if (running)
    begin
      if (ip_load)
        next_ip = ip_in;
      if (flags_wr)
        next_flags = (flags_in & FLAGS_WMASK) | FLAGS_SET;
      if (ex_go && s2_class == OPC_CR0_WRITE)
      begin
        next_cr0 = s2_data & CR0_WMASK;
        next_cr0[CR0_PE_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      instruction_pointer      <= IP_RST;
      revision_report_register <= 32'h0000_0000;
      cr0_value                <= CR0_RST;
      flags_register           <= FLAGS_RST;
      default_32bit_code_size  <= 1'b1;
    end
    else
    begin
      instruction_pointer      <= next_ip;
      revision_report_register <= next_rev;
      cr0_value                <= next_cr0;
      flags_register           <= next_flags;
      default_32bit_code_size  <= next_code32;
    end
  end

  assign protected_mode = cr0_value[CR0_PE_BIT];

  // ***************************************************************
  // Segment shadow registers
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_SEGS; g++)
    begin : g_seg
      logic [31:0] base;
      logic [31:0] limit;
      logic [31:0] next_base;
      logic [31:0] next_limit;

      always_comb
      begin
        next_base  = base;
        next_limit = limit;
        if (arch_load)
        begin
          next_base  = SEG_BASE_RST;
          next_limit = SEG_LIMIT_RST;
        end
        else if (running && seg_load && seg_sel == 3'(g))
        begin
          next_base  = seg_base_in;
          next_limit = seg_limit_in;
        end
      end

      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          base  <= SEG_BASE_RST;
          limit <= SEG_LIMIT_RST;
        end
        else
        begin
          base  <= next_base;
          limit <= next_limit;
        end
      end

      assign seg_base_all[g*32 +: 32]  = base;
      assign seg_limit_all[g*32 +: 32] = limit;
    end
  endgenerate

  // ***************************************************************
  // Address path and instruction cache
  // ***************************************************************
  logic [31:0]         ic_data [IC_WORDS];
  logic [IC_TAG_W-1:0] ic_tag  [IC_WORDS];
  logic [IC_WORDS-1:0] ic_valid;
  logic [IC_WORDS-1:0] next_ic_valid;
  logic [IC_IDX_W-1:0] f_idx;
  logic [IC_IDX_W-1:0] w_idx;
  logic                next_hit;

  assign f_idx = fetch_addr[IC_IDX_W+1:2];
  assign w_idx = fill_addr[IC_IDX_W+1:2];

  always_comb
  begin
    next_ic_valid = ic_valid;
    if (arch_load)
      next_ic_valid = '0;
    else if (running && fill_valid)
      next_ic_valid[w_idx] = 1'b1;
    next_hit = running & fetch_req & ic_valid[f_idx]
             & (ic_tag[f_idx] == fetch_addr[31:IC_IDX_W+2]);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ic_valid         <= '0;
      fetch_hit        <= 1'b0;
      fetch_data       <= 32'h0000_0000;
      physical_address <= 32'h0000_0000;
    end
    else
    begin
      ic_valid         <= next_ic_valid;
      fetch_hit        <= next_hit;
      fetch_data       <= ic_data[f_idx];
      physical_address <= linear_address;
    end
  end

  // Cache storage has no reset; the valid bits guard it
  always_ff @(posedge mclk)
  begin
    if (running && fill_valid)
    begin
      ic_data[w_idx] <= fill_data;
      ic_tag[w_idx]  <= fill_addr[31:IC_IDX_W+2];
    end
  end

  // ***************************************************************
  // System data bus
  // ***************************************************************
  logic [15:0] din_s1;
  logic [15:0] din_s2;
  logic        next_oe_n;
  logic [15:0] next_dout;

  always_comb
  begin
    next_oe_n = ~(running & bus_wr_req);
    next_dout = bus_wr_req ? bus_wr_data : system_data_bus_out;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      system_data_bus_oe_n <= 1'b1;
      system_data_bus_out  <= 16'h0000;
      din_s1               <= 16'h0000;
      din_s2               <= 16'h0000;
      bus_rd_data          <= 16'h0000;
    end
    else
    begin
      system_data_bus_oe_n <= next_oe_n;
      system_data_bus_out  <= next_dout;
      din_s1               <= system_data_bus_in;
      din_s2               <= din_s1;
      bus_rd_data          <= din_s2;
    end
  end

endmodule

/* File: cpucr_core_ctl_props.sv */
/*
  Port-level checks for the core control block.
  Assumes it is bound onto cpucr_core_ctl; one clock mclk, reset rst_n.
*/
`timescale 1ns/1ps
module cpucr_core_ctl_props
  import cpucr_pkg::*;
#(
  parameter logic [31:0] REVISION_CODE = 32'h0000_0A5C // Arbitrary value
)
(
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic                   byte_high_enable_strap,
  input wire logic                   core_clk,
  input wire logic                   boot_16bit,
  input wire logic                   op_valid,
  input wire logic                   op_ready,
  input wire logic [7:0]             op_byte0,
  input wire logic [7:0]             op_byte1,
  input wire logic [7:0]             op_modrm,
  input wire logic                   escape_trap,
  input wire logic                   invalid_opcode_trap,
  input wire logic                   nop_done,
  input wire logic                   exec_done,
  input wire logic [31:0]            cr0_value,
  input wire logic [31:0]            flags_register,
  input wire logic [NUM_SEGS*32-1:0] seg_base_all,
  input wire logic [NUM_SEGS*32-1:0] seg_limit_all,
  input wire logic [31:0]            instruction_pointer,
  input wire logic [31:0]            revision_report_register,
  input wire logic                   protected_mode,
  input wire logic                   default_32bit_code_size,
  input wire logic [31:0]            linear_address,
  input wire logic [31:0]            physical_address,
  input wire logic                   bus_wr_req,
  input wire logic [15:0]            bus_wr_data,
  input wire logic [15:0]            system_data_bus_out,
  input wire logic                   system_data_bus_oe_n
);
  import cpucr_pkg::*;

  logic is_esc;
  logic is_inv;
  logic is_crx;
  logic any_done;
  assign is_esc = (op_byte0 >= OP_ESC_LO) && (op_byte0 <= OP_ESC_HI);
  assign is_inv = (op_byte0 == OP_TWO_BYTE) && ((op_byte1 == OP2_WB_INVAL) ||
                  ((op_byte1 == OP2_GROUP7) && (op_modrm[5:3] == GRP7_TE_INVAL)));
  assign is_crx = (op_byte0 == OP_TWO_BYTE) && (op_byte1 inside {OP2_MOV_TO_CR, OP2_MOV_FR_CR})
                  && (op_modrm[5:3] inside {CR_NUM_2, CR_NUM_3});
  assign any_done = escape_trap || invalid_opcode_trap || nop_done || exec_done;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ***************************************************************
  // Pipeline answers, three edges after the taking edge
  // ***************************************************************
  sequence s_take(hit);
    op_valid && op_ready && hit;
  endsequence
  property p_answer(hit, pulse);
    s_take(hit) ##3 op_ready |-> pulse;
  endproperty

  a_escape_trap: assert property (p_answer(is_esc, escape_trap))
    else $error("escape opcode did not trap");
  a_wait_nop: assert property (p_answer(op_byte0 == OP_WAIT, nop_done))
    else $error("wait not a no-op");
  a_unimpl_invalid: assert property (p_answer(is_inv, invalid_opcode_trap))
    else $error("unimplemented opcode not refused");
  a_absent_cr_nop: assert property (p_answer(is_crx, nop_done))
    else $error("absent CR access not a no-op");
  a_single_answer: assert property (any_done |->
    $onehot({escape_trap, invalid_opcode_trap, nop_done, exec_done})
    && $past(op_valid && op_ready, 3))
    else $error("answer without a take");

  // ***************************************************************
  // Reset state, modes, clock, address and bus
  // ***************************************************************
  a_reset_load: assert property ($rose(op_ready) |->
    instruction_pointer == IP_RST && seg_base_all == '0
    && seg_limit_all == {NUM_SEGS{SEG_LIMIT_RST}}
    && revision_report_register == REVISION_CODE && boot_16bit == byte_high_enable_strap)
    else $error("reset state wrong");
  a_mode_fixed: assert property (protected_mode && default_32bit_code_size
    && cr0_value[CR0_PE_BIT] && !cr0_value[31] && (cr0_value & ~(CR0_WMASK | CR0_RST)) == 0)
    else $error("mode or reserved control bits wrong");
  a_flags_reserved: assert property (((flags_register & ~(FLAGS_WMASK | FLAGS_SET)) == 0)
    && (flags_register & FLAGS_SET) == FLAGS_SET)
    else $error("reserved flag bits wrong");
  a_clk_halved: assert property ($past(rst_n) |-> core_clk != $past(core_clk))
    else $error("core clock not toggling");
  a_addr_pass: assert property ($past(rst_n) |-> physical_address == $past(linear_address))
    else $error("address not passed through");
  a_bus_drive: assert property ($past(rst_n) |->
    (system_data_bus_oe_n != $past(bus_wr_req))
    && (system_data_bus_oe_n || system_data_bus_out == $past(bus_wr_data)))
    else $error("data bus driven without a write request");
endmodule

/* File: cpucr_sysbus_model.sv */
/*
  Board and boot ROM side of the system data bus and the width strap.
  Assumes the bus carries pull-ups and the strap is held by the board.
*/
`timescale 1ns/1ps
module cpucr_sysbus_model
(
  input  wire logic        strap_level,
  input  wire logic        rom_en,
  input  wire logic [15:0] rom_word,
  input  wire logic [15:0] bus_out,
  input  wire logic        bus_oe_n,
  output logic             strap_pin,
  output logic [15:0]      bus_pin
);
  // Strap is a fixed board level
  assign strap_pin = strap_level;
  // Released bus carries the ROM word when rom_en is set, else floats to the pull-up level
  assign bus_pin = !bus_oe_n ? bus_out : (rom_en ? rom_word : 16'hFFFF);
endmodule

/* File: tb.sv */
/*
  Self-checking bench for the core control block.
  Assumes cpucr_pkg, the design, the checker and the bus model are compiled first.
*/
`timescale 1ns/1ps
module tb;
  import cpucr_pkg::*;
  localparam logic [31:0] REV = 32'h0000_3C1E; // Arbitrary value

  logic mclk = 1'b0, rst_n = 1'b0, power_good_input = 1'b0, byte_high_enable_strap;
  logic op_valid = 1'b0, ip_load = 1'b0, flags_wr = 1'b0, seg_load = 1'b0;
  logic fetch_req = 1'b0, fill_valid = 1'b0, bus_wr_req = 1'b0, rom_en = 1'b0, strap = 1'b1;
  logic [7:0] op_byte0 = 8'h00, op_byte1 = 8'h00, op_modrm = 8'h00;
  logic [2:0] seg_sel = 3'h0;
  logic [31:0] op_data = '0, ip_in = '0, flags_in = '0, seg_base_in = '0, seg_limit_in = '0;
  logic [31:0] linear_address = '0, fetch_addr = '0, fill_addr = '0, fill_data = '0;
  logic [15:0] bus_wr_data = '0, rom_word = '0, system_data_bus_in;
  logic core_clk, core_reset, boot_16bit, op_ready, escape_trap, invalid_opcode_trap;
  logic nop_done, exec_done, protected_mode, default_32bit_code_size, fetch_hit;
  logic system_data_bus_oe_n;
  logic [NUM_SEGS*32-1:0] seg_base_all, seg_limit_all;
  logic [31:0] result_data, instruction_pointer, revision_report_register, cr0_value;
  logic [31:0] flags_register, physical_address, fetch_data;
  logic [15:0] bus_rd_data, system_data_bus_out;
  int err_count = 0;
  int checks_done = 0;

  always #10 mclk = ~mclk;

  cpucr_core_ctl #(.REVISION_CODE(REV)) i_dut (.*);
  cpucr_sysbus_model i_bus (.strap_level(strap), .rom_en(rom_en), .rom_word(rom_word),
    .bus_out(system_data_bus_out), .bus_oe_n(system_data_bus_oe_n),
    .strap_pin(byte_high_enable_strap), .bus_pin(system_data_bus_in));

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic power_up(input logic s);
    int n;
    @(posedge mclk);
    power_good_input <= 1'b0;
    strap <= s;
    repeat (6) @(posedge mclk);
    power_good_input <= 1'b1;
    for (n = 0; n < 20 && op_ready !== 1'b1; n++)
      @(posedge mclk);
    #1;
  endtask

  task automatic t_reset_state(input logic s);
    for (int i = 0; i < NUM_SEGS; i++)
    begin
      check(seg_base_all[i*32+:32], SEG_BASE_RST);
      check(seg_limit_all[i*32+:32], SEG_LIMIT_RST);
    end
    check(instruction_pointer, IP_RST);
    check(revision_report_register, REV);
    check({protected_mode, cr0_value}, {1'b1, CR0_RST});
    check(default_32bit_code_size, 1'b1);
    check(core_reset, 1'b0);
    check(flags_register, FLAGS_RST);
    check(boot_16bit, s);
    check({system_data_bus_oe_n, bus_rd_data}, 17'h1FFFF);
  endtask

  // Exp order: escape, invalid, no-op, executed
  task automatic run_op(input logic [7:0] b0, b1, m, input logic [31:0] d, input logic [3:0] exp);
    @(posedge mclk);
    op_valid <= 1'b1;
    {op_byte0, op_byte1, op_modrm, op_data} <= {b0, b1, m, d};
    @(posedge mclk);
    op_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check({escape_trap, invalid_opcode_trap, nop_done, exec_done}, exp);
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_opcodes();
    for (int i = 0; i < 8; i++)
      run_op(OP_ESC_LO + 8'(i), 8'h00, 8'h00, '0, 4'h8);
    run_op(OP_WAIT, 8'h00, 8'h00, '0, 4'h2);
    run_op(8'h0F, 8'h09, 8'h00, '0, 4'h4);
    run_op(8'h0F, 8'h01, 8'h38, '0, 4'h4);
    run_op(8'h0F, 8'h01, 8'hF8, '0, 4'h4);
    run_op(8'h0F, 8'h22, 8'hD0, 32'hFFFF_FFFF, 4'h2);
    run_op(8'h0F, 8'h22, 8'hD8, 32'hFFFF_FFFF, 4'h2);
    check(cr0_value, CR0_RST);
    run_op(8'h0F, 8'h20, 8'hD0, '0, 4'h2);
    check(result_data, CR_UNDEF_READ);
    run_op(8'h0F, 8'h22, 8'hC8, '0, 4'h4);
    run_op(8'h0F, 8'h22, 8'hC0, 32'hFFFF_FFFF, 4'h1);
    check(cr0_value, (32'hFFFF_FFFF & CR0_WMASK) | CR0_RST);
    run_op(8'h0F, 8'h20, 8'hC0, '0, 4'h1);
    check(result_data, (32'hFFFF_FFFF & CR0_WMASK) | CR0_RST);
    run_op(8'h90, 8'h00, 8'h00, '0, 4'h1);
  endtask

  task automatic t_regs();
    @(posedge mclk);
    {flags_wr, ip_load, seg_load, seg_sel} <= {3'b111, 3'h5};
    {flags_in, ip_in, seg_base_in, seg_limit_in} <= {32'hFFFF_FFFF, 32'h0000_1000,
      32'h0001_0000, 32'h0000_FFFF};
    linear_address <= 32'hDEAD_BEEF;
    @(posedge mclk);
    {flags_wr, ip_load, seg_load} <= 3'b000;
    #1;
    check(flags_register, FLAGS_WMASK | FLAGS_SET);
    check(instruction_pointer, 32'h0000_1000);
    check({seg_base_all[5*32+:32], seg_limit_all[5*32+:32]}, 64'h0001_0000_0000_FFFF);
    check(physical_address, 32'hDEAD_BEEF);
  endtask

  task automatic t_cache();
    @(posedge mclk);
    {fill_valid, fill_addr, fill_data} <= {1'b1, 32'h0000_0100, 32'hA5A5_0001};
    @(posedge mclk);
    fill_valid <= 1'b0;
    {fetch_req, fetch_addr} <= {1'b1, 32'h0000_0100};
    @(posedge mclk);
    fetch_addr <= 32'h0000_0500;
    #1;
    check({fetch_hit, fetch_data}, {1'b1, 32'hA5A5_0001});
    @(posedge mclk);
    fetch_req <= 1'b0;
    #1;
    check(fetch_hit, 1'b0);
  endtask

  task automatic t_bus();
    @(posedge mclk);
    {bus_wr_req, bus_wr_data} <= {1'b1, 16'hC35A};
    @(posedge mclk);
    bus_wr_req <= 1'b0;
    #1;
    check({system_data_bus_oe_n, system_data_bus_out}, 17'h0C35A);
    @(posedge mclk);
    {rom_en, rom_word} <= {1'b1, 16'h5A3C};
    #1;
    check(system_data_bus_oe_n, 1'b1);
    repeat (4) @(posedge mclk);
    rom_en <= 1'b0;
    #1;
    check(bus_rd_data, 16'h5A3C);
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    power_up(1'b1);
    t_reset_state(1'b1);
    t_opcodes();
    t_regs();
    t_cache();
    t_bus();
    power_up(1'b0);
    t_reset_state(1'b0);
    print_verdict();
  end

  initial
  begin
    repeat (5000) @(posedge mclk);
    err_count++;
    print_verdict();
  end
endmodule

bind cpucr_core_ctl cpucr_core_ctl_props #(.REVISION_CODE(REVISION_CODE)) i_props (.*);
